// ### inc/irq_route_pkg.sv
package irq_route_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Geometry
  localparam int NUM_LINES = 8;
  localparam int NIB_W = 4;
  localparam int NUM_IRQ = 16;
  localparam int NUM_FUNC = 2;
  localparam int DMA_GNT_LINE = 6;
  localparam int DMA_REQ_LINE = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration offsets, dword aligned
  localparam logic [7:0] CFG_INT_PIN = 8'h3C;
  localparam logic [7:0] CFG_GPIO = 8'h88;
  localparam logic [7:0] CFG_ROUTE = 8'h8C;
  localparam logic [7:0] CFG_DEVCTL = 8'h90;
  localparam logic [7:0] CFG_SRCSEL = 8'hC0;

  // Byte lanes of the narrow registers
  localparam int LANE_PIN = 1;
  localparam int LANE_GENERAL_PIN_THREE = 3;
  localparam int LANE_DEVCTL = 2;

  // Field positions
  localparam int MODE_LSB = 1;
  localparam int GENERAL_PIN_THREE_FS_LSB = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Values
  localparam logic [7:0] DEVCTL_RESET = 8'h06;
  localparam logic [7:0] GENERAL_PIN_THREE_RESET = 8'h00;
  localparam logic [31:0] ROUTE_RESET = 32'h0000_0000;
  localparam logic [15:0] SRCSEL_RESET = 16'h0000;
  localparam logic [1:0] GENERAL_PIN_THREE_FS_INTA = 2'h2;
  localparam logic [7:0] PIN_CODE_A = 8'h01;
  localparam logic [7:0] PIN_CODE_B = 8'h02;
  localparam logic [3:0] NIB_OFF = 4'h0;
  localparam logic [3:0] NIB_INTB = 4'h1;

  // Interrupt signalling modes
  typedef enum logic [1:0] {
    MODE_PAR_PCI = 2'b00,
    MODE_PAR_IRQ = 2'b01,
    MODE_SER_IRQ = 2'b10,
    MODE_SER_ALL = 2'b11
  } irq_mode_e;

  // One configuration access
  typedef struct packed {
    logic wr;
    logic rd;
    logic func;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } cfg_req_s;

endpackage

// ### design/route_line.sv
`timescale 1ns/1ps
module route_line
  import irq_route_pkg::*;
#(
  parameter bit CAN_INTB = 1'b0
)(
  // Routing nibble of this line
  input wire logic [NIB_W-1:0] i_nibble,
  // Request sources
  input wire logic [NUM_IRQ-1:0] i_irq_vec,
  input wire logic i_par_irq,
  input wire logic i_intb_req,
  input wire logic i_intb_ok,
  // Line result
  output logic o_level,
  output logic o_drive,
  output logic o_routed
);

  logic as_intb;

  // Only the lowest line may carry INTB
  assign as_intb = CAN_INTB && (i_nibble == NIB_INTB);
  // Zero nibble leaves the line free
  assign o_routed = (i_nibble != NIB_OFF);

  // Nibble value is the IRQ number
  always_comb begin
    if (as_intb) begin
      o_level = i_intb_req;
      o_drive = i_intb_ok;
    end else begin
      o_level = o_routed & i_par_irq & i_irq_vec[i_nibble];
      o_drive = o_routed & i_par_irq;
    end
  end

endmodule

// ### design/irq_route_top.sv
`timescale 1ns/1ps
// What this block does
// R1 - each routed line picks any of fifteen IRQs, line 0 only IRQ2 to IRQ15
// R2 - routed top lines override DMA pins
// R3 - lower six lines always usable for IRQs
// R4 - software selects mode before using routed lines
// R5 - eight parallel IRQ lines at once
// R6 - nibble value is the driven IRQ number
// R7 - one routing register shared by both functions
// R8 - unrouted top lines stay with DMA
// R9 - parallel PCI pins off when PCI serialized
// R10 - two-bit mode field; shared pin is INTB in both parallel modes
// R11 - lowest nibble 0001b carries PCI INTB
// R12 - general pin three carries INTA when selected
// R13 - interrupt pin code depends on function, mode
// R14 - reset mode is fully serialized
// R15 - card status, functional irqs route separately
// R16 - zero nibble asserts no IRQ
module irq_route_top
  import irq_route_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Configuration access
  input wire cfg_req_s i_cfg,
  output logic [31:0] o_cfg_rdata,
  output logic o_cfg_rvalid,
  // Card interrupt sources, one per function
  input wire logic [NUM_FUNC-1:0] i_card_func_irq,
  input wire logic [NUM_FUNC-1:0] i_card_status_change,
  // PC/PCI DMA side of the shared lines
  input wire logic i_pcpci_dma_request,
  input wire logic i_pcpci_dma_grant,
  output logic o_pcpci_dma_grant,
  // Routed IRQ line pins
  output logic [NUM_LINES-1:0] o_routed_irq_line,
  output logic [NUM_LINES-1:0] o_routed_irq_line_oe,
  // Parallel PCI interrupts
  output logic o_pci_inta,
  output logic o_pci_intb,
  output logic o_general_pin_three,
  output logic o_general_pin_three_oe,
  // Serialized stream requests
  output logic o_serial_pin_is_intb,
  output logic [NUM_IRQ-1:0] o_serialized_irq_stream,
  output logic o_serial_inta,
  output logic o_serial_intb
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic rst_meta;
  logic rst_n_sync;
  logic [31:0] legacy_irq_route_map;
  logic [7:0] dev_ctrl;
  logic [7:0] general_pin_three_ctrl;
  logic [15:0] src_sel;
  irq_mode_e irq_mode;
  logic par_pci;
  logic par_irq;
  logic pin_intb;
  logic ser_irq;
  logic [NUM_IRQ-1:0] irq_vec;
  logic [NUM_FUNC-1:0] to_pci;
  logic pci_a_req;
  logic pci_b_req;
  logic [NUM_LINES-1:0] line_lvl;
  logic [NUM_LINES-1:0] line_drv;
  logic [NUM_LINES-1:0] line_rt;
  logic [NUM_LINES-1:0] next_line;
  logic [NUM_LINES-1:0] next_oe;
  logic [7:0] pin_code;
  logic [31:0] next_rdata;
  logic general_pin_three_inta;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta <= 1'b0;
      rst_n_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n_sync <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Routing register, function number ignored
  always_ff @(posedge i_clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      legacy_irq_route_map <= ROUTE_RESET;
    end else if (i_cfg.wr && i_cfg.addr == CFG_ROUTE) begin // R7
      for (int b = 0; b < 4; b++) begin
        if (i_cfg.be[b]) begin
          legacy_irq_route_map[b*8 +: 8] <= i_cfg.wdata[b*8 +: 8];
        end
      end
    end
  end

  // Device control byte, mode in bits 2:1
  always_ff @(posedge i_clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      dev_ctrl <= DEVCTL_RESET; // R14
    end else if (i_cfg.wr && i_cfg.addr == CFG_DEVCTL && i_cfg.be[LANE_DEVCTL]) begin
      dev_ctrl <= i_cfg.wdata[LANE_DEVCTL*8 +: 8]; // R10
    end
  end

  // General pin three control byte
  always_ff @(posedge i_clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      general_pin_three_ctrl <= GENERAL_PIN_THREE_RESET;
    end else if (i_cfg.wr && i_cfg.addr == CFG_GPIO && i_cfg.be[LANE_GENERAL_PIN_THREE]) begin
      general_pin_three_ctrl <= i_cfg.wdata[LANE_GENERAL_PIN_THREE*8 +: 8];
    end
  end

  // Source select: one nibble per source, zero keeps it on PCI
  always_ff @(posedge i_clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      src_sel <= SRCSEL_RESET;
    end else if (i_cfg.wr && i_cfg.addr == CFG_SRCSEL) begin
      for (int b = 0; b < 2; b++) begin
        if (i_cfg.be[b]) begin
          src_sel[b*8 +: 8] <= i_cfg.wdata[b*8 +: 8];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode
  assign irq_mode = irq_mode_e'(dev_ctrl[MODE_LSB +: 2]); // R10
  assign par_pci = (irq_mode != MODE_SER_ALL); // R9
  assign par_irq = (irq_mode == MODE_PAR_IRQ); // R4
  assign ser_irq = (irq_mode == MODE_SER_IRQ) || (irq_mode == MODE_SER_ALL);
  // Shared serial pin is INTB only when no stream runs
  assign pin_intb = (irq_mode == MODE_PAR_PCI) || par_irq; // R10
  assign general_pin_three_inta = (general_pin_three_ctrl[GENERAL_PIN_THREE_FS_LSB +: 2] == GENERAL_PIN_THREE_FS_INTA);

  // Collect sources: functional and status change pick own IRQs
  always_comb begin
    logic [NIB_W-1:0] fsel;
    logic [NIB_W-1:0] csel;
    fsel = NIB_OFF;
    csel = NIB_OFF;
    irq_vec = '0;
    to_pci = '0;
    for (int f = 0; f < NUM_FUNC; f++) begin
      fsel = src_sel[f*8 +: NIB_W];
      csel = src_sel[f*8+NIB_W +: NIB_W];
      // Unselected source falls back to the PCI pin
      if (fsel == NIB_OFF) begin
        to_pci[f] = to_pci[f] | i_card_func_irq[f];
      end else begin
        irq_vec[fsel] = irq_vec[fsel] | i_card_func_irq[f]; // R15
      end
      if (csel == NIB_OFF) begin
        to_pci[f] = to_pci[f] | i_card_status_change[f];
      end else begin
        irq_vec[csel] = irq_vec[csel] | i_card_status_change[f]; // R15
      end
    end
  end

  // Function 1 folds onto INTA in serial IRQ mode
  assign pci_a_req = to_pci[0] | (to_pci[1] & (irq_mode == MODE_SER_IRQ));
  assign pci_b_req = to_pci[1] & (irq_mode != MODE_SER_IRQ);

  ////////////////////////////////////////////////////////////////////////////
  // One router per line, any of IRQ1 to IRQ15, line 0 only IRQ2 to IRQ15
  for (genvar i = 0; i < NUM_LINES; i++) begin : g_line
    route_line #(
      .CAN_INTB(i == 0)
    ) u_line (
      .i_nibble(legacy_irq_route_map[i*NIB_W +: NIB_W]), // R6
      .i_irq_vec(irq_vec), // R1
      .i_par_irq(par_irq), // R5
      .i_intb_req(pci_b_req), // R11
      .i_intb_ok(par_pci),
      .o_level(line_lvl[i]),
      .o_drive(line_drv[i]),
      .o_routed(line_rt[i])
    );
  end

  // Top two lines fall back to DMA when unrouted
  always_comb begin
    next_line = line_lvl; // R3
    next_oe = line_drv; // R16
    if (!line_rt[DMA_REQ_LINE]) begin
      next_line[DMA_REQ_LINE] = i_pcpci_dma_request; // R8
      next_oe[DMA_REQ_LINE] = 1'b1;
    end
    if (!line_rt[DMA_GNT_LINE]) begin
      next_line[DMA_GNT_LINE] = 1'b0; // R8
      next_oe[DMA_GNT_LINE] = 1'b0;
    end
  end

  // Line pins
  always_ff @(posedge i_clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      o_routed_irq_line <= '0;
      o_routed_irq_line_oe <= '0;
    end else begin
      o_routed_irq_line <= next_line; // R2
      o_routed_irq_line_oe <= next_oe;
    end
  end

  // Grant seen only while its pin is not an IRQ
  always_ff @(posedge i_clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      o_pcpci_dma_grant <= 1'b0;
    end else begin
      o_pcpci_dma_grant <= i_pcpci_dma_grant & ~line_rt[DMA_GNT_LINE]; // R2
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parallel PCI pins
  always_ff @(posedge i_clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      o_pci_inta <= 1'b0;
      o_pci_intb <= 1'b0;
      o_serial_pin_is_intb <= 1'b0;
      o_general_pin_three <= 1'b0;
      o_general_pin_three_oe <= 1'b0;
    end else begin
      o_pci_inta <= pci_a_req & par_pci; // R9
      o_pci_intb <= pci_b_req & pin_intb; // R10
      o_serial_pin_is_intb <= pin_intb;
      o_general_pin_three <= pci_a_req & par_pci & general_pin_three_inta; // R12
      o_general_pin_three_oe <= general_pin_three_inta;
    end
  end

  // Serialized stream requests, handed to the frame engine
  always_ff @(posedge i_clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      o_serialized_irq_stream <= '0;
      o_serial_inta <= 1'b0;
      o_serial_intb <= 1'b0;
    end else begin
      o_serialized_irq_stream <= ser_irq ? irq_vec : '0;
      o_serial_inta <= pci_a_req & ~par_pci;
      o_serial_intb <= pci_b_req & ~par_pci;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read side; pin code per function and mode
  assign pin_code = (i_cfg.func && irq_mode != MODE_SER_IRQ) ? PIN_CODE_B : PIN_CODE_A; // R13

  always_comb begin
    next_rdata = '0;
    case (i_cfg.addr)
      CFG_INT_PIN: next_rdata[LANE_PIN*8 +: 8] = pin_code;
      CFG_GPIO: next_rdata[LANE_GENERAL_PIN_THREE*8 +: 8] = general_pin_three_ctrl;
      CFG_ROUTE: next_rdata = legacy_irq_route_map;
      CFG_DEVCTL: next_rdata[LANE_DEVCTL*8 +: 8] = dev_ctrl;
      CFG_SRCSEL: next_rdata[15:0] = src_sel;
      default: next_rdata = '0;
    endcase
  end

  // Read answer one cycle after the strobe
  always_ff @(posedge i_clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      o_cfg_rdata <= '0;
      o_cfg_rvalid <= 1'b0;
    end else begin
      o_cfg_rvalid <= i_cfg.rd;
      o_cfg_rdata <= i_cfg.rd ? next_rdata : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!rst_n_sync);

  chk_reset_mode: assert property ( // R14
    $rose(rst_n_sync) |-> irq_mode == MODE_SER_ALL)
    else $error("mode not serialized after reset");

  chk_par_pci_off: assert property ( // R9
    irq_mode == MODE_SER_ALL |=> !o_pci_inta && !o_pci_intb)
    else $error("parallel pci active while serialized");

  chk_pin_code: assert property ( // R13
    i_cfg.rd && i_cfg.addr == CFG_INT_PIN && i_cfg.func && irq_mode == MODE_SER_IRQ
    |=> o_cfg_rvalid && o_cfg_rdata[LANE_PIN*8 +: 8] == PIN_CODE_A)
    else $error("function 1 pin code wrong");

  chk_route_shared: assert property ( // R7
    i_cfg.wr && i_cfg.addr == CFG_ROUTE && i_cfg.be == 4'hF
    |=> legacy_irq_route_map == $past(i_cfg.wdata))
    else $error("routing write lost");

  chk_line_drive: assert property ( // R6
    par_irq && legacy_irq_route_map[15:12] != NIB_OFF
    && irq_vec[legacy_irq_route_map[15:12]]
    |=> o_routed_irq_line[3] && o_routed_irq_line_oe[3])
    else $error("line 3 missed its irq");

  chk_line_idle: assert property ( // R16
    legacy_irq_route_map[23:20] == NIB_OFF |=> !o_routed_irq_line_oe[5])
    else $error("unrouted line driven");

  chk_dma_share: assert property ( // R8
    legacy_irq_route_map[31:28] == NIB_OFF
    |=> o_routed_irq_line[DMA_REQ_LINE] == $past(i_pcpci_dma_request))
    else $error("dma request not passed");

  chk_irq_wins: assert property ( // R2
    legacy_irq_route_map[27:24] != NIB_OFF |=> !o_pcpci_dma_grant)
    else $error("grant seen on routed line");

  chk_intb_line0: assert property ( // R11
    legacy_irq_route_map[3:0] == NIB_INTB && par_pci
    |=> o_routed_irq_line[0] == $past(pci_b_req) && o_routed_irq_line_oe[0])
    else $error("line 0 not carrying intb");

  chk_general_pin_three_inta: assert property ( // R12
    general_pin_three_inta && par_pci && pci_a_req |=> o_general_pin_three)
    else $error("pin three missed inta");

endmodule

// ### test/host_irq_model.sv
`timescale 1ns/1ps
module host_irq_model
  import irq_route_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Routed line pins as seen on the board
  input wire logic [NUM_LINES-1:0] i_routed_irq_line,
  input wire logic [NUM_LINES-1:0] i_routed_irq_line_oe,
  // Slow grant answer when high
  input wire logic i_slow,
  // Chipset view
  output logic o_pcpci_dma_grant,
  output logic [NUM_LINES-1:0] o_line_view
);
  logic [NUM_LINES-1:0] last;
  logic [2:0] wait_cnt;
  logic req_seen;

  ////////////////////////////////////////////////////////////////////////////
  // Last driven level per line; a released line shows its inverse, so stale data never matches
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      last <= '0;
    end else begin
      last <= (i_routed_irq_line & i_routed_irq_line_oe) | (last & ~i_routed_irq_line_oe);
    end
  end
  assign o_line_view = (i_routed_irq_line & i_routed_irq_line_oe) |
                       (~last & ~i_routed_irq_line_oe);

  // Grant after one or four cycles of a request seen on the top line
  assign req_seen = i_routed_irq_line_oe[DMA_REQ_LINE] & i_routed_irq_line[DMA_REQ_LINE];
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_cnt <= 3'h0;
    end else if (!req_seen) begin
      wait_cnt <= 3'h0;
    end else if (wait_cnt != 3'h7) begin
      wait_cnt <= wait_cnt + 3'h1;
    end
  end
  assign o_pcpci_dma_grant = req_seen && (wait_cnt >= (i_slow ? 3'h4 : 3'h1));
endmodule

// ### test/legacy_irq_mux_and_pci_int_routing_test.sv
`timescale 1ns/1ps
module legacy_irq_mux_and_pci_int_routing_test
  import irq_route_pkg::*;
();
  logic clk, rst_n, rvalid, dreq, slow, gnt_out, inta, intb, p3, p3oe, spib, sia, sib;
  logic [1:0] fi, sc;
  logic [7:0] line, line_oe, line_view;
  logic [15:0] sstr;
  logic [31:0] rdata;
  wire gnt_in;
  cfg_req_s cfg;
  int n_fail, cmp_count;

  irq_route_top i_dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_cfg(cfg), .o_cfg_rdata(rdata),
    .o_cfg_rvalid(rvalid), .i_card_func_irq(fi), .i_card_status_change(sc),
    .i_pcpci_dma_request(dreq), .i_pcpci_dma_grant(gnt_in), .o_pcpci_dma_grant(gnt_out),
    .o_routed_irq_line(line), .o_routed_irq_line_oe(line_oe), .o_pci_inta(inta),
    .o_pci_intb(intb), .o_general_pin_three(p3), .o_general_pin_three_oe(p3oe),
    .o_serial_pin_is_intb(spib), .o_serialized_irq_stream(sstr), .o_serial_inta(sia),
    .o_serial_intb(sib));

  host_irq_model i_host (.i_clk_sys(clk), .i_rst_n(rst_n), .i_routed_irq_line(line),
    .i_routed_irq_line_oe(line_oe), .i_slow(slow), .o_pcpci_dma_grant(gnt_in),
    .o_line_view(line_view));

  ////////////////////////////////////////////////////////////////////////////
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task finish_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Lines reflect a write one edge after the strobe edge
  task cfg_wr(input logic f, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(posedge clk); #1;
    cfg = '{wr:1'b1, rd:1'b0, func:f, addr:a, be:b, wdata:d};
    @(posedge clk); #1;
    cfg.wr = 1'b0;
    @(posedge clk); #1;
  endtask

  // Read data stands only in the cycle after the strobe
  task cfg_rd(input logic f, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk); #1;
    cfg = '{wr:1'b0, rd:1'b1, func:f, addr:a, be:4'hF, wdata:32'h0};
    @(posedge clk); #1;
    cfg.rd = 1'b0;
    check({31'h0, rvalid}, 32'h1);
    check(rdata, exp);
  endtask

  task set_mode(input logic [1:0] m);
    cfg_wr(1'b0, CFG_DEVCTL, 4'b0100, {13'h0, m, 17'h0});
  endtask

  task settle;
    repeat (2) @(posedge clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    cfg = '0;
    fi = 2'b00;
    sc = 2'b00;
    dreq = 1'b0;
    slow = 1'b1;
    n_fail = 0;
    cmp_count = 0;
    rst_n = 1'b0;
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk);
    cfg_rd(1'b0, CFG_DEVCTL, 32'h0006_0000);
    cfg_rd(1'b0, CFG_ROUTE, 32'h0000_0000);
    cfg_rd(1'b0, 8'h40, 32'h0000_0000);
    check(spib, 1'b0);
    // Pin codes and PCI outputs across every mode
    fi = 2'b11;
    for (int m = 0; m < 4; m++) begin
      set_mode(m[1:0]);
      cfg_rd(1'b1, CFG_INT_PIN, {16'h0, (m == 2) ? PIN_CODE_A : PIN_CODE_B, 8'h0});
      cfg_rd(1'b0, CFG_INT_PIN, {16'h0, PIN_CODE_A, 8'h0});
      check(inta, m != 3);
      check(sia, m == 3);
      check(sib, m == 3);
      check(intb, m < 2);
      check(spib, m < 2);
    end
    // Pin three as INTA, then INTB on the shared pin
    set_mode(MODE_PAR_PCI);
    cfg_wr(1'b0, CFG_GPIO, 4'b1000, {GENERAL_PIN_THREE_FS_INTA, 30'h0});
    check({p3oe, p3}, 2'b11);
    fi = 2'b10;
    settle;
    check({p3, intb}, 2'b01);
    // Lowest line carries INTB
    set_mode(MODE_PAR_IRQ);
    cfg_wr(1'b1, CFG_ROUTE, 4'hF, 32'h0000_0001);
    check({line_oe[0], line[0]}, 2'b11);
    check(line_oe[6:1], 6'h00);
    fi = 2'b00;
    settle;
    check(line[0], 1'b0);
    // Unrouted top lines serve DMA, with a slow chipset grant
    dreq = 1'b1;
    repeat (4) settle;
    check({line_oe[7], line[7], gnt_out, line_view[7]}, 4'b1111);
    cfg_wr(1'b1, CFG_ROUTE, 4'hF, 32'hFCBA_9543);
    cfg_rd(1'b0, CFG_ROUTE, 32'hFCBA_9543);
    check({line[7], gnt_out}, 2'b00);
    // Functional to IRQ5, status change to IRQ9
    cfg_wr(1'b0, CFG_SRCSEL, 4'b0011, 32'h0000_0095);
    fi = 2'b01;
    settle;
    check(line, 8'h04);
    fi = 2'b00;
    sc = 2'b01;
    settle;
    check(line, 8'h08);
    sc = 2'b00;
    // IRQ1 to IRQ15 on all eight lines at once
    fi = 2'b01;
    // IRQ1 on line 0 turns it into INTB, idle here
    for (int n = 1; n < 16; n++) begin
      cfg_wr(1'b0, CFG_SRCSEL, 4'b0011, {28'h0, n[3:0]});
      cfg_wr(1'b0, CFG_ROUTE, 4'hF, {8{n[3:0]}});
      check(line, (n == 1) ? 8'hFE : 8'hFF);
      check(line_oe, 8'hFF);
    end
    set_mode(MODE_SER_IRQ);
    settle;
    check(sstr, 16'h8000);
    // Reset again in mid-run: registers back to defaults
    @(posedge clk);
    #1 rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk);
    cfg_rd(1'b0, CFG_DEVCTL, 32'h0006_0000);
    cfg_rd(1'b1, CFG_ROUTE, 32'h0000_0000);
    check(line_oe, 8'h80);
    check(sstr, 16'h0000);
    finish_test;
  end

  // Watchdog well beyond the expected run
  initial begin
    #200us;
    n_fail++;
    finish_test;
  end
endmodule
